// *** shared/vtc_map.vh ***
// constants for the video timing command and interrupt unit
`ifndef VTC_MAP_VH
`define VTC_MAP_VH
`define VTC_A_CMD        3'h0
`define VTC_A_STAT       3'h1
`define VTC_A_IRQ        3'h2
`define VTC_A_CUR_LO     3'h3
`define VTC_A_CUR_HI     3'h4
`define VTC_A_PTR_LO     3'h5
`define VTC_A_PTR_HI     3'h6
`define VTC_A_LPEN_LO    3'h7
`define VTC_F_LPEN       0
`define VTC_F_READY      1
`define VTC_F_SPLIT      2
`define VTC_F_LZERO      3
`define VTC_F_VERTICAL_BLANK_FLAG     4
`define VTC_F_IDLE       5
`define VTC_C_MRESET     8'h00
`define VTC_C_RD_PTR     8'ha4
`define VTC_C_WR_PTR     8'ha2
`define VTC_C_INC_CUR    8'ha9
`define VTC_C_RD_CUR     8'hac
`define VTC_C_WR_CUR     8'haa
`define VTC_C_RD_CUR_INC 8'had
`define VTC_C_WR_CUR_INC 8'hab
`define VTC_C_FILL       8'hbb
`define VTC_P_LOADIR     4'h1
`define VTC_P_ONOFF      3'h1
`define VTC_P_CLRFLG     3'h2
`define VTC_P_SETMSK     3'h3
`define VTC_P_CLRMSK     3'h4
`define VTC_IR_MAX       4'ha
`define VTC_INC_CYCLES   2'h3
`endif

// *** hw/vtc_sync2.v ***
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module vtc_sync2 (
   input  wire mclk,
   input  wire rst_n,
   input  wire d,
   output wire q
);
   reg s1_r;
   reg s2_r;
   always @(posedge mclk) begin
      if (!rst_n) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
      end
   end
   assign q = s2_r;
endmodule // vtc_sync2
`default_nettype wire

// *** hw/vtc_wr_edge.v ***
// synchronised write strobe with trailing edge pulse
`timescale 1ns/10ps
`default_nettype none
module vtc_wr_edge (
   input  wire mclk,
   input  wire rst_n,
   input  wire strobe_n,
   output wire trail
);
   wire lvl;
   reg  lvl_d_r;
   vtc_sync2 u_s (
      .mclk  (mclk),
      .rst_n (rst_n),
      .d     (~strobe_n),
      .q     (lvl)
   );
   always @(posedge mclk) begin
      if (!rst_n) lvl_d_r <= 1'b0;
      else lvl_d_r <= lvl;
   end
   // one pulse when the active-low strobe goes back high
   assign trail = lvl_d_r & ~lvl;
endmodule // vtc_wr_edge
`default_nettype wire

// *** hw/vtc_cmd_irq.v ***
// command decoder, address registers and interrupt/status logic
`timescale 1ns/10ps
`default_nettype none
`include "vtc_map.vh"
module vtc_cmd_irq (
   input  wire        mclk,
   input  wire        rst_n,
   input  wire [2:0]  bus_addr,
   input  wire [7:0]  bus_wdata,
   input  wire        bus_wr_n,
   input  wire        bus_rd_n,
   input  wire        bus_ce_n,
   output reg  [7:0]  bus_rdata,
   input  wire [13:0] char_addr,
   input  wire        line_zero_start,
   input  wire        vfp_start,
   input  wire [6:0]  row_number,
   input  wire [6:0]  split_row_value,
   input  wire        active_display,
   input  wire        hblank,
   input  wire        screen_start_load,
   input  wire        first_control_input,
   input  wire        light_pen_pin,
   input  wire        access_done,
   output wire        interrupt_request_out,
   output reg         cursor_out,
   output reg         blank_out,
   output reg         sync_hold_low,
   output reg         display_address_float,
   output reg  [3:0]  init_ptr,
   output reg         access_req,
   output reg         access_write,
   output reg  [13:0] access_addr
);
   // pin-side inputs pass two flops
   wire wr_trail;
   wire rd_trail;
   wire pen_s;
   wire rd_lvl;
   vtc_wr_edge u_wr (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .strobe_n (bus_wr_n | bus_ce_n),
      .trail    (wr_trail)
   );
   vtc_wr_edge u_rd (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .strobe_n (bus_rd_n | bus_ce_n),
      .trail    (rd_trail)
   );
   vtc_sync2 u_pen (
      .mclk  (mclk),
      .rst_n (rst_n),
      .d     (light_pen_pin),
      .q     (pen_s)
   );
   vtc_sync2 u_rdl (
      .mclk  (mclk),
      .rst_n (rst_n),
      .d     (~(bus_rd_n | bus_ce_n)),
      .q     (rd_lvl)
   );

   // address and data pass two flops, in step with the strobe synchronisers
   reg [2:0] addr_p_r;
   reg [7:0] wdata_p_r;
   reg [2:0] addr_r;
   reg [7:0] wdata_r;
   always @(posedge mclk) begin
      if (!rst_n) begin
         addr_p_r  <= 3'h0;
         wdata_p_r <= 8'h00;
         addr_r    <= 3'h0;
         wdata_r   <= 8'h00;
      end else begin
         addr_p_r  <= bus_addr;
         wdata_p_r <= bus_wdata;
         addr_r    <= addr_p_r;
         wdata_r   <= wdata_p_r;
      end
   end

   localparam S_IDLE = 4'b0001;
   localparam S_WAIT = 4'b0010;
   localparam S_XFER = 4'b0100;
   localparam S_INC  = 4'b1000;

   function is_delayed;
      input [7:0] c;
      begin
         case (c)
            `VTC_C_RD_PTR, `VTC_C_WR_PTR, `VTC_C_INC_CUR, `VTC_C_RD_CUR,
            `VTC_C_WR_CUR, `VTC_C_RD_CUR_INC, `VTC_C_WR_CUR_INC,
            `VTC_C_FILL: is_delayed = 1'b1;
            default: is_delayed = 1'b0;
         endcase
      end
   endfunction

   reg [3:0]  state_r;
   reg [7:0]  cmd_r;
   reg [1:0]  inc_cnt_r;
   reg [4:0]  flag_r;
   reg [4:0]  mask_r;
   reg [4:0]  irq_r;
   reg        idle_r;
   reg        cursor_en_r;
   reg        display_on_r;
   reg        pen_en_r;
   reg        pen_lock_r;
   reg        on_next_field_r;
   reg [13:0] cursor_r;
   reg [13:0] pointer_r;
   reg [13:0] lpen_r;

   wire cmd_wr = wr_trail & (addr_r == `VTC_A_CMD);
   wire [7:0] c = wdata_r;
   wire mreset = cmd_wr & (c == `VTC_C_MRESET);
   wire pen_rd = rd_trail & ((addr_r == `VTC_A_LPEN_LO));
   wire pen_hit = pen_s & pen_en_r & ~pen_lock_r;
   wire [13:0] cur_inc = cursor_r + 14'h0001;

   // events this cycle, bit order: pen, ready, split, line zero, vertical_blank_flag
   reg [4:0] ev;
   reg [4:0] clr;
   always @* begin
      ev = 5'h00;
      ev[`VTC_F_LPEN]   = pen_hit;
      ev[`VTC_F_READY]  = 1'b0;
      ev[`VTC_F_SPLIT]  = line_zero_start & (row_number == split_row_value);
      ev[`VTC_F_LZERO]  = line_zero_start;
      ev[`VTC_F_VERTICAL_BLANK_FLAG] = vfp_start;
      if (state_r == S_XFER && access_done && !(cmd_r == `VTC_C_FILL &&
          access_addr != pointer_r))
         ev[`VTC_F_READY] = ~(cmd_r == `VTC_C_RD_CUR_INC ||
                              cmd_r == `VTC_C_WR_CUR_INC);
      if (state_r == S_INC && inc_cnt_r == 2'h0)
         ev[`VTC_F_READY] = 1'b1;
      clr = 5'h00;
      if (cmd_wr && (c[7:5] == `VTC_P_CLRFLG || c[7:5] == `VTC_P_SETMSK))
         clr = c[4:0];
      if (pen_rd)
         clr[`VTC_F_LPEN] = 1'b1;
      if (screen_start_load)
         clr[`VTC_F_SPLIT] = 1'b1;
   end

   always @(posedge mclk) begin
      if (!rst_n || mreset) begin
         flag_r          <= 5'h00;
         irq_r           <= 5'h00;
         mask_r          <= 5'h00;
         idle_r          <= 1'b1;
         cursor_en_r     <= 1'b0;
         display_on_r    <= 1'b0;
         pen_en_r        <= 1'b0;
         pen_lock_r      <= 1'b0;
         on_next_field_r <= 1'b0;
         init_ptr        <= 4'h0;
         state_r         <= S_IDLE;
         cmd_r           <= 8'h00;
         inc_cnt_r       <= 2'h0;
         access_req      <= 1'b0;
         access_write    <= 1'b0;
         access_addr     <= 14'h0000;
         blank_out       <= 1'b1;
         sync_hold_low   <= 1'b1;
         display_address_float <= 1'b0;
         if (!rst_n) begin
            cursor_r  <= 14'h0000;
            pointer_r <= 14'h0000;
            lpen_r    <= 14'h0000;
         end
      end else begin
         // set wins over clear in the same cycle
         flag_r <= (flag_r & ~clr) | ev;
         irq_r  <= (irq_r & ~clr) | (ev & mask_r);
         if (pen_hit) begin
            lpen_r     <= char_addr;
            pen_lock_r <= 1'b1;
         end else if (pen_rd)
            pen_lock_r <= 1'b0;
         if (on_next_field_r && vfp_start) begin
            blank_out       <= 1'b0;
            on_next_field_r <= 1'b0;
         end
         if (wr_trail) begin
            case (addr_r)
               `VTC_A_CUR_LO: cursor_r[7:0]  <= wdata_r;
               `VTC_A_CUR_HI: cursor_r[13:8] <= wdata_r[5:0];
               `VTC_A_PTR_LO: pointer_r[7:0] <= wdata_r;
               `VTC_A_PTR_HI: pointer_r[13:8] <= wdata_r[5:0];
               default: ;
            endcase
         end
         // instantaneous commands other than master reset leave idle as it is and never set ready; clear-flag and set-mask clear ready when their bit 1 is set
         if (cmd_wr) begin
            if (c[7:4] == `VTC_P_LOADIR && c[3:0] <= `VTC_IR_MAX)
               init_ptr <= c[3:0];
            if (c[7:5] == `VTC_P_ONOFF) begin
               if (c[1])
                  pen_en_r <= c[0];
               if (c[4])
                  cursor_en_r <= c[0];
               if (c[3]) begin
                  display_on_r <= c[0];
                  if (!c[0]) begin
                     blank_out             <= 1'b1;
                     on_next_field_r       <= 1'b0;
                     display_address_float <= c[2];
                  end else begin
                     display_address_float <= 1'b0;
                     sync_hold_low         <= 1'b0;
                     if (c[2])
                        on_next_field_r <= 1'b1;
                     else
                        blank_out <= 1'b0;
                  end
               end
            end
            if (c[7:5] == `VTC_P_SETMSK)
               mask_r <= mask_r | c[4:0];
            if (c[7:5] == `VTC_P_CLRMSK)
               mask_r <= mask_r & ~c[4:0];
            if (is_delayed(c) && idle_r) begin
               cmd_r  <= c;
               idle_r <= 1'b0;
               if (c == `VTC_C_INC_CUR) begin
                  state_r   <= S_INC;
                  inc_cnt_r <= `VTC_INC_CYCLES - 2'h1;
               end else if (c == `VTC_C_FILL) begin
                  state_r     <= S_XFER;
                  blank_out   <= 1'b1;
                  access_req  <= 1'b1;
                  access_write <= 1'b1;
                  access_addr <= cursor_r;
               end else
                  state_r <= S_WAIT;
            end
         end
         case (state_r)
            S_IDLE: ;
            S_WAIT: begin
               // active display defers to horizontal blank
               if (!active_display || hblank || !display_on_r) begin
                  state_r      <= S_XFER;
                  access_req   <= 1'b1;
                  access_write <= ~cmd_r[2];
                  access_addr  <= (cmd_r[3]) ? cursor_r : pointer_r;
               end
            end
            S_XFER: begin
               if (access_done) begin
                  if (cmd_r == `VTC_C_FILL) begin
                     if (access_addr == pointer_r) begin
                        access_req <= 1'b0;
                        cursor_r   <= pointer_r;
                        state_r    <= S_IDLE;
                        idle_r     <= 1'b1;
                        on_next_field_r <= display_on_r;
                     end else
                        access_addr <= access_addr + 14'h0001;
                  end else begin
                     access_req <= 1'b0;
                     if (cmd_r[0] && cmd_r[3]) begin
                        state_r   <= S_INC;
                        inc_cnt_r <= 2'h0;
                     end else begin
                        state_r <= S_IDLE;
                        idle_r  <= 1'b1;
                     end
                  end
               end
            end
            S_INC: begin
               if (inc_cnt_r == 2'h0) begin
                  cursor_r <= cur_inc;
                  state_r  <= S_IDLE;
                  idle_r   <= 1'b1;
               end else
                  inc_cnt_r <= inc_cnt_r - 2'h1;
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   always @(posedge mclk) begin
      if (!rst_n || mreset)
         cursor_out <= 1'b0;
      else
         cursor_out <= cursor_en_r & (char_addr == cursor_r);
   end

   assign interrupt_request_out = |irq_r;

   // read data registered while the strobe is low
   always @(posedge mclk) begin
      if (!rst_n)
         bus_rdata <= 8'h00;
      else if (rd_lvl) begin
         case (addr_r)
            `VTC_A_STAT:   bus_rdata <= {2'b00, idle_r, flag_r};
            `VTC_A_IRQ:    bus_rdata <= {3'b000, irq_r};
            `VTC_A_CUR_LO: bus_rdata <= cursor_r[7:0];
            `VTC_A_CUR_HI: bus_rdata <= {2'b00, cursor_r[13:8]};
            `VTC_A_PTR_LO: bus_rdata <= pointer_r[7:0];
            `VTC_A_PTR_HI: bus_rdata <= {2'b00, pointer_r[13:8]};
            `VTC_A_LPEN_LO: bus_rdata <= lpen_r[7:0];
            default:       bus_rdata <= {2'b00, lpen_r[13:8]};
         endcase
      end
   end
endmodule // vtc_cmd_irq
`default_nettype wire

// *** dv/vtc_cmd_irq_sva.sv ***
// port-level checks for the command and interrupt unit
`timescale 1ns/10ps
`default_nettype none
module vtc_cmd_irq_sva (
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        bus_ce_n,
   input wire logic        hblank,
   input wire logic        active_display,
   input wire logic        access_done,
   input wire logic        interrupt_request_out,
   input wire logic        cursor_out,
   input wire logic        blank_out,
   input wire logic        sync_hold_low,
   input wire logic        display_address_float,
   input wire logic [3:0]  init_ptr,
   input wire logic        access_req,
   input wire logic        access_write,
   input wire logic [13:0] access_addr
);
   // cycles since the host last selected the part
   logic [3:0] quiet_r;
   always_ff @(posedge mclk) begin
      if (!rst_n || !bus_ce_n)
         quiet_r <= 4'h0;
      else if (quiet_r != 4'hf)
         quiet_r <= quiet_r + 4'h1;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   AST_RST_STATE: assert property ($rose(rst_n) |-> blank_out && sync_hold_low
      && !interrupt_request_out && init_ptr == 4'h0) else $error("reset state wrong");
   AST_SYNC_BLANK: assert property (sync_hold_low |-> blank_out)
      else $error("sync held without blank");
   AST_PTR_RANGE: assert property (init_ptr <= 4'ha)
      else $error("init pointer above ten");
   AST_PTR_QUIET: assert property (!$stable(init_ptr) |-> quiet_r < 4'he)
      else $error("init pointer moved without a write");
   AST_IRQ_FALL: assert property ($fell(interrupt_request_out) |-> quiet_r < 4'he)
      else $error("interrupt dropped without host action");
   AST_FLOAT_BLANK: assert property (display_address_float |-> blank_out)
      else $error("address bus floated while display on");
   AST_ACC_HOLD: assert property (access_req && !access_done |=> access_req
      && $stable(access_addr) && $stable(access_write)) else $error("access request unstable");
   AST_ACC_WAIT: assert property ($rose(access_req) |-> hblank || $past(hblank)
      || !$past(active_display) || blank_out) else $error("access during active line");
   cover property ($rose(access_req));
   cover property ($fell(interrupt_request_out));
   cover property ($rose(cursor_out));
endmodule // vtc_cmd_irq_sva
bind vtc_cmd_irq vtc_cmd_irq_sva chk_u (.mclk, .rst_n, .bus_ce_n, .hblank, .active_display,
   .access_done, .interrupt_request_out, .cursor_out, .blank_out, .sync_hold_low,
   .display_address_float, .init_ptr, .access_req, .access_write, .access_addr);
`default_nettype wire

// *** dv/vtc_host_model.sv ***
// host cpu model driving the command unit's register port
`timescale 1ns/10ps
`default_nettype none
module vtc_host_model (
   input wire logic       mclk,
   output logic [2:0]     bus_addr,
   output logic [7:0]     bus_wdata,
   output logic           bus_wr_n,
   output logic           bus_rd_n,
   output logic           bus_ce_n,
   output logic           first_control_input,
   input wire logic [7:0] bus_rdata
);
   initial begin
      bus_addr = 3'h0;
      bus_wdata = 8'h00;
      bus_wr_n = 1'h1;
      bus_rd_n = 1'h1;
      bus_ce_n = 1'h1;
      first_control_input = 1'h1;
   end
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk) #1 bus_addr = a;
      bus_wdata = d;
      bus_ce_n = 1'h0;
      bus_wr_n = 1'h0;
      repeat (4) @(posedge mclk);
      #1 bus_wr_n = 1'h1;
      bus_ce_n = 1'h1;
      // address and data outlive the strobe by the sampling delay
      repeat (6) @(posedge mclk);
      #1 bus_addr = ~a;
      bus_wdata = ~d;
   endtask
   task rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge mclk) #1 bus_addr = a;
      bus_ce_n = 1'h0;
      bus_rd_n = 1'h0;
      repeat (5) @(posedge mclk);
      #1 d = bus_rdata;
      bus_rd_n = 1'h1;
      bus_ce_n = 1'h1;
      repeat (4) @(posedge mclk);
      #1;
   endtask
   task power_up;
      wr(3'h0, 8'h00);
      wr(3'h0, 8'h00);
   endtask
endmodule // vtc_host_model
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking testbench for the command and interrupt unit
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic        mclk = 1'h0, rst_n = 1'h0, active_display = 1'h0, hblank = 1'h0;
   logic [4:0]  ev = 5'h00;
   logic [6:0]  row_number = 7'h00, split_row_value = 7'h00;
   logic [13:0] char_addr = 14'h0000, access_addr;
   logic [7:0]  bus_wdata, bus_rdata;
   logic [3:0]  init_ptr;
   logic [2:0]  bus_addr;
   logic        bus_wr_n, bus_rd_n, bus_ce_n, first_control_input, interrupt_request_out;
   logic        cursor_out, blank_out, sync_hold_low, display_address_float;
   logic        access_req, access_write;
   int          bad_count = 0, n_compared = 0;
   always #12.5 mclk = ~mclk;
   vtc_cmd_irq dut_u (.mclk, .rst_n, .bus_addr, .bus_wdata, .bus_wr_n, .bus_rd_n, .bus_ce_n,
      .bus_rdata, .char_addr, .line_zero_start(ev[0]), .vfp_start(ev[1]), .row_number,
      .split_row_value, .active_display, .hblank, .screen_start_load(ev[2]),
      .first_control_input, .light_pen_pin(ev[3]), .access_done(ev[4]),
      .interrupt_request_out, .cursor_out, .blank_out, .sync_hold_low,
      .display_address_float, .init_ptr, .access_req, .access_write, .access_addr);
   vtc_host_model host_u (.mclk, .bus_addr, .bus_wdata, .bus_wr_n, .bus_rd_n, .bus_ce_n,
      .first_control_input, .bus_rdata);
   task print_verdict;
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input string nm, input logic [13:0] e, input logic [13:0] g);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task rdc(input logic [2:0] a, input logic [7:0] e);
      logic [7:0] v;
      host_u.rd(a, v);
      chk($sformatf("reg%0d", a), {6'h00, e}, {6'h00, v});
   endtask
   task pulse(input int i, input int n);
      @(posedge mclk) #1 ev[i] = 1'h1;
      repeat (n) @(posedge mclk);
      #1 ev[i] = 1'h0;
      repeat (8) @(posedge mclk);
      #1;
   endtask
   task wait_req;
      repeat (40) if (!access_req) @(posedge mclk);
      #1;
   endtask
   task t_reset;
      chk("blank", 14'h1, blank_out);
      chk("sync", 14'h1, sync_hold_low);
      chk("ptr", 14'h0, init_ptr);
      rdc(3'h2, 8'h00);
      host_u.power_up;
      rdc(3'h1, 8'h20);
   endtask
   task t_load_ir;
      host_u.wr(3'h0, 8'h1a);
      chk("ptr", 14'ha, init_ptr);
      host_u.wr(3'h0, 8'h1b);
      chk("ptr", 14'ha, init_ptr);
      rdc(3'h1, 8'h20);
   endtask
   task t_irq;
      host_u.wr(3'h0, 8'h70);
      pulse(1, 1);
      chk("irq", 14'h1, interrupt_request_out);
      row_number = 7'h05;
      split_row_value = 7'h05;
      pulse(0, 1);
      rdc(3'h1, 8'h3c);
      rdc(3'h2, 8'h10);
      pulse(2, 1);
      rdc(3'h1, 8'h38);
      host_u.wr(3'h0, 8'h50);
      chk("irq", 14'h0, interrupt_request_out);
      host_u.wr(3'h0, 8'h90);
      pulse(1, 1);
      chk("irq", 14'h0, interrupt_request_out);
      rdc(3'h1, 8'h38);
      host_u.wr(3'h0, 8'h5f);
      rdc(3'h1, 8'h20);
   endtask
   task t_cursor;
      host_u.wr(3'h3, 8'hff);
      host_u.wr(3'h4, 8'h3f);
      host_u.wr(3'h0, 8'ha9);
      rdc(3'h3, 8'h00);
      rdc(3'h4, 8'h00);
      rdc(3'h1, 8'h22);
      host_u.wr(3'h0, 8'h29);
      chk("cursor", 14'h0, cursor_out);
      host_u.wr(3'h0, 8'h31);
      chk("cursor", 14'h1, cursor_out);
      char_addr = 14'h0001;
      repeat (4) @(posedge mclk);
      #1 chk("cursor", 14'h0, cursor_out);
   endtask
   task t_delayed;
      host_u.wr(3'h5, 8'h23);
      host_u.wr(3'h6, 8'h01);
      host_u.wr(3'h0, 8'h42);
      active_display = 1'h1;
      host_u.wr(3'h0, 8'ha4);
      chk("req", 14'h0, access_req);
      rdc(3'h1, 8'h00);
      hblank = 1'h1;
      wait_req;
      chk("addr", 14'h0123, access_addr);
      chk("dir", 14'h0, access_write);
      pulse(4, 1);
      rdc(3'h1, 8'h22);
      host_u.wr(3'h0, 8'hab);
      wait_req;
      chk("addr", 14'h0000, access_addr);
      chk("dir", 14'h1, access_write);
      pulse(4, 1);
      rdc(3'h3, 8'h01);
   endtask
   task t_lpen;
      host_u.wr(3'h0, 8'h23);
      char_addr = 14'h0456;
      pulse(3, 3);
      char_addr = 14'h0789;
      pulse(3, 3);
      rdc(3'h1, 8'h23);
      rdc(3'h7, 8'h56);
      rdc(3'h0, 8'h04);
      rdc(3'h1, 8'h22);
   endtask
   task t_fill;
      hblank = 1'h0;
      host_u.wr(3'h5, 8'h03);
      host_u.wr(3'h6, 8'h00);
      host_u.wr(3'h0, 8'h42);
      host_u.wr(3'h0, 8'hbb);
      chk("blank", 14'h1, blank_out);
      chk("addr", 14'h0001, access_addr);
      chk("dir", 14'h1, access_write);
      pulse(4, 1);
      pulse(4, 1);
      chk("addr", 14'h0003, access_addr);
      chk("req", 14'h1, access_req);
      pulse(4, 1);
      chk("req", 14'h0, access_req);
      rdc(3'h3, 8'h03);
      rdc(3'h1, 8'h22);
      chk("blank", 14'h1, blank_out);
      pulse(1, 1);
      chk("blank", 14'h0, blank_out);
      char_addr = 14'h0003;
      repeat (2) @(posedge mclk);
      #1 chk("cursor", 14'h1, cursor_out);
   endtask
   task t_mreset;
      host_u.wr(3'h0, 8'h2c);
      chk("float", 14'h1, display_address_float);
      chk("blank", 14'h1, blank_out);
      host_u.wr(3'h0, 8'h70);
      host_u.wr(3'h0, 8'h00);
      chk("blank", 14'h1, blank_out);
      chk("sync", 14'h1, sync_hold_low);
      chk("ptr", 14'h0, init_ptr);
      chk("cursor", 14'h0, cursor_out);
      rdc(3'h1, 8'h20);
      pulse(1, 1);
      chk("irq", 14'h0, interrupt_request_out);
      rdc(3'h1, 8'h30);
   endtask
   initial begin
      repeat (2) @(posedge mclk);
      #1 rst_n = 1'h1;
      t_reset;
      t_load_ir;
      t_irq;
      t_cursor;
      t_delayed;
      t_lpen;
      t_fill;
      t_mreset;
      print_verdict;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      bad_count++;
      print_verdict;
   end
endmodule // testbench
`default_nettype wire
